//--- hdl/acr_card.sv
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/1ns
module acr_card
	import acr_pkg::*;
#(
	parameter logic [7:0] ECM_INS_DEF = 8'h34,
	parameter int         MEM_WORDS   = 32
) (
	input  wire logic                     clock,
	input  wire logic                     rst_b,
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [acr_pkg::ACR_AW-1:0] wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	input  wire logic                     cmd_valid,
	input  wire logic [7:0]               cmd_byte,
	output logic                          cmd_ready,
	output logic                          rsp_valid,
	output logic      [7:0]               rsp_byte,
	output logic                          rsp_last,
	input  wire logic                     rsp_ready
);
	import acr_pkg::*;

	typedef enum logic [1:0] {
		ACR_ST_IDLE = 2'b00,
		ACR_ST_SEND = 2'b01
	} acr_state_e;

	localparam int MW = $clog2(MEM_WORDS);

	acr_cmd_if   cmd ();
	acr_state_e  state;
	acr_kind_e   kind;
	acr_kind_e   next_kind;
	logic [5:0]  ctrl;
	logic [7:0]  ecm_ins;
	logic [31:0] instr_reg;
	logic [31:0] rc_reg;
	logic [31:0] sw_reg;
	logic [7:0]  pos;
	logic [7:0]  out_pos;
	logic [7:0]  data_len;
	logic [7:0]  next_data_len;
	logic [7:0]  rsp_count;
	logic [7:0]  last_lc;
	logic [7:0]  next_byte;
	logic [7:0]  field;
	logic [7:0]  n_eff;
	logic [7:0]  mem_byte;
	logic [7:0]  cnt_byte;
	logic [MW+1:0] byte_idx;
	logic [31:0] mem_word;
	logic [31:0] next_rdata;
	logic        wb_req;
	logic        wb_wr;
	logic        load;
	logic        reg_hit;
	logic        mem_hit;
	logic [15:0] instr_now;
	logic [15:0] rc_now;
	logic [7:0]  rec_code;

	assign wb_req  = wb_cyc_i && wb_stb_i;
	// write takes effect at the edge where the master sees ack
	assign wb_wr   = wb_req && wb_we_i && wb_ack_o;
	// words past the end of the memory read as zero instead of aliasing onto it
	assign mem_hit = (wb_adr_i[ACR_AW-1:2] >= ACR_MEM_BASE)
	                 && ({1'b0, wb_adr_i[ACR_AW-1:2]} < (8'(ACR_MEM_BASE) + 8'(MEM_WORDS)));
	assign reg_hit = wb_adr_i[ACR_AW-1:2] <= ACR_REG_STAT;

	acr_cmd_parse u_parse (
		.clock    (clock),
		.rst_b    (rst_b),
		.take     (cmd_valid && cmd_ready),
		.cmd_byte (cmd_byte),
		.cmd      (cmd.parser)
	);

	acr_prof_mem #(.WORDS(MEM_WORDS)) u_mem (
		.clock    (clock),
		.rst_b    (rst_b),
		.wr_en    (wb_wr && mem_hit),
		.word_idx (wb_adr_i[MW+1:2]),
		.wr_sel   (wb_sel_i),
		.wr_data  (wb_dat_i),
		.rd_word  (mem_word),
		.byte_idx (byte_idx),
		.byte_out (mem_byte)
	);

	// wishbone classic: ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req && !wb_ack_o;
			if (wb_req && !wb_ack_o) begin
				wb_dat_o <= next_rdata;
			end
		end
	end

	// unmapped words read as zero and ignore writes
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (mem_hit) begin
			next_rdata = mem_word;
		end else begin
			case (wb_adr_i[ACR_AW-1:2])
				ACR_REG_CTRL:  next_rdata = {26'h0, ctrl};
				ACR_REG_INS:   next_rdata = {24'h0, ecm_ins};
				ACR_REG_INSTR: next_rdata = instr_reg;
				ACR_REG_RC:    next_rdata = rc_reg;
				ACR_REG_SW:    next_rdata = sw_reg;
				ACR_REG_STAT:  next_rdata = {8'h0, rsp_count, last_lc, 5'h0, kind, state == ACR_ST_SEND};
				default:       next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ctrl      <= ACR_CTRL_RST;
			ecm_ins   <= 8'h00;
			instr_reg <= ACR_INSTR_RST;
			rc_reg    <= ACR_RC_RST;
			sw_reg    <= ACR_SW_RST;
		end else if (wb_wr && reg_hit) begin
			case (wb_adr_i[ACR_AW-1:2])
				ACR_REG_CTRL:  ctrl <= wb_sel_i[0] ? wb_dat_i[5:0] : ctrl;
				ACR_REG_INS:   ecm_ins <= wb_sel_i[0] ? wb_dat_i[7:0] : ecm_ins;
				ACR_REG_INSTR: instr_reg <= wb_dat_i;
				ACR_REG_RC:    rc_reg <= wb_dat_i;
				ACR_REG_SW:    sw_reg <= wb_dat_i;
				default:       ctrl <= ctrl;
			endcase
		end
	end

	// instruction code for control messages has no fixed value; zero in the register means the default
	logic [7:0] ecm_ins_now;
	assign ecm_ins_now = (ecm_ins != 8'h00) ? ecm_ins : ECM_INS_DEF;

	// command classification and latched response length
	always_comb begin
		next_kind = ACR_KIND_NONE;
		if (cmd.hdr_ok && (cmd.ins == ACR_INS_INIT) && (cmd.lc == ACR_P_ZERO)) begin
			next_kind = ACR_KIND_INIT;
		end else if (cmd.hdr_ok && (cmd.ins == ecm_ins_now) && (cmd.lc != ACR_P_ZERO)) begin
			next_kind = ACR_KIND_ECM;
		end
	end

	// identifier count is clamped to ACR_SMID_MAX (eight), whatever the profile memory size
	assign cnt_byte = mem_byte;
	always_comb begin
		case (next_kind)
			ACR_KIND_INIT: next_data_len = ACR_PRE_LEN + ACR_UNIT_HDR + ACR_INIT_FIX + 8'(n_eff << 1);
			ACR_KIND_ECM:  next_data_len = ACR_PRE_LEN + ACR_UNIT_HDR + ACR_ECM_FIX;
			default:       next_data_len = 8'h00;
		endcase
	end

	assign instr_now = ctrl[ACR_CTRL_GROUP] ? instr_reg[31:16] : instr_reg[15:0];
	assign rc_now    = (kind == ACR_KIND_ECM) && !ctrl[ACR_CTRL_VIEW] ? rc_reg[31:16] : rc_reg[15:0];

	always_comb begin
		case (ctrl[ACR_CTRL_REC +: 2])
			2'b01:   rec_code = ACR_REC_ALLOWED;
			2'b10:   rec_code = ACR_REC_BUYER;
			default: rec_code = ACR_REC_NONE;
		endcase
	end

	// byte generator: field index counts from the first command-specific byte
	assign field = pos - (ACR_PRE_LEN + ACR_UNIT_HDR);
	always_comb begin
		byte_idx = (MW+2)'(ACR_CNT_FIELD - 8'h01);
		if (state == ACR_ST_SEND) begin
			if (kind == ACR_KIND_ECM) begin
				byte_idx = (MW+2)'(ACR_MEM_ODD) + (MW+2)'(field);
			end else if (field < ACR_TYPE_FIELD) begin
				byte_idx = (MW+2)'(field);
			end else begin
				byte_idx = (MW+2)'(field - 8'h01);
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			n_eff <= 8'h00;
		end else if (state == ACR_ST_IDLE) begin
			n_eff <= (cnt_byte > ACR_SMID_MAX) ? ACR_SMID_MAX : cnt_byte;
		end
	end

	always_comb begin
		next_byte = 8'h00;
		if (pos == data_len) begin
			next_byte = sw_byte_hi();
		end else if (pos == data_len + 8'h01) begin
			next_byte = sw_byte_lo();
		end else begin
			case (pos)
				8'h00: next_byte = ACR_UNIT_ZERO;
				8'h01: next_byte = data_len - ACR_PRE_LEN;
				8'h02: next_byte = instr_now[15:8];
				8'h03: next_byte = instr_now[7:0];
				8'h04: next_byte = rc_now[15:8];
				8'h05: next_byte = rc_now[7:0];
				default: begin
					if (kind == ACR_KIND_ECM) begin
						if (field < ACR_KEYS_LEN) begin
							next_byte = ctrl[ACR_CTRL_VIEW] ? mem_byte : 8'h00;
						end else begin
							next_byte = rec_code;
						end
					end else if (field == ACR_TYPE_FIELD) begin
						next_byte = ctrl[ACR_CTRL_STD] ? ACR_TYPE_STANDARD : ACR_TYPE_PREPAID;
					end else if (field == ACR_CNT_FIELD) begin
						next_byte = n_eff;
					end else begin
						next_byte = mem_byte;
					end
				end
			endcase
		end
	end

	function automatic logic [7:0] sw_byte_hi();
		return (kind == ACR_KIND_NONE) ? sw_reg[31:24] : sw_reg[15:8];
	endfunction

	function automatic logic [7:0] sw_byte_lo();
		return (kind == ACR_KIND_NONE) ? sw_reg[23:16] : sw_reg[7:0];
	endfunction

	// in ACR_ST_SEND, up to the second status byte, a new byte is loaded whenever the output stage is empty or being drained
	assign load = (state == ACR_ST_SEND) && (!rsp_valid || rsp_ready) && (pos <= data_len + 8'h01);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state     <= ACR_ST_IDLE;
			cmd_ready <= 1'b0;
			kind      <= ACR_KIND_NONE;
			data_len  <= 8'h00;
			pos       <= 8'h00;
			last_lc   <= 8'h00;
		end else begin
			case (state)
				ACR_ST_IDLE: begin
					cmd_ready <= !cmd.done;
					if (cmd.done) begin
						state    <= ACR_ST_SEND;
						kind     <= next_kind;
						data_len <= next_data_len;
						last_lc  <= cmd.lc;
						pos      <= 8'h00;
					end
				end
				ACR_ST_SEND: begin
					if (load) begin
						pos <= pos + 8'h01;
					end
					if (rsp_valid && rsp_ready && rsp_last) begin
						state     <= ACR_ST_IDLE;
						cmd_ready <= 1'b1;
					end
				end
				default: begin
					state <= ACR_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rsp_valid <= 1'b0;
			rsp_byte  <= 8'h00;
			rsp_last  <= 1'b0;
			out_pos   <= 8'h00;
			rsp_count <= 8'h00;
		end else if (load) begin
			rsp_valid <= 1'b1;
			rsp_byte  <= next_byte;
			rsp_last  <= (pos == data_len + 8'h01);
			out_pos   <= pos;
		end else if (rsp_valid && rsp_ready) begin
			rsp_valid <= 1'b0;
			rsp_last  <= 1'b0;
			rsp_count <= rsp_last ? rsp_count + 8'h01 : rsp_count;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	a_unit_number_zero: assert property (rsp_valid && out_pos == 8'h00 && kind != ACR_KIND_NONE |-> rsp_byte == ACR_UNIT_ZERO)
		else $error("unit number byte is not zero");
	a_unit_length_byte: assert property (rsp_valid && out_pos == 8'h01 && kind != ACR_KIND_NONE |-> rsp_byte == data_len - 8'h02)
		else $error("unit length does not match payload");
	a_init_length: assert property (rsp_valid && out_pos == 8'h01 && kind == ACR_KIND_INIT |-> rsp_byte == 8'(8'h37 + 8'(n_eff << 1)))
		else $error("initial settings length wrong");
	a_card_type_code: assert property (rsp_valid && out_pos == 8'h0E && kind == ACR_KIND_INIT |-> rsp_byte inside {8'h00, 8'h01})
		else $error("card type byte out of range");
	a_group_instruction: assert property (rsp_valid && out_pos == 8'h02 && kind == ACR_KIND_INIT && ctrl[1] |-> rsp_byte == instr_reg[31:24])
		else $error("fetch card id instruction missing");
	a_keys_zeroed: assert property (rsp_valid && kind == ACR_KIND_ECM && out_pos >= 8'h06 && out_pos <= 8'h15 && !ctrl[0] |-> rsp_byte == 8'h00)
		else $error("content key leaked without viewing permission");
	a_record_code: assert property (rsp_valid && kind == ACR_KIND_ECM && out_pos == 8'h16 |-> rsp_byte inside {8'h00, 8'h01, 8'h10})
		else $error("recording control code invalid");
	a_return_code: assert property (rsp_valid && kind == ACR_KIND_ECM && out_pos == 8'h04 |-> rsp_byte == (ctrl[0] ? rc_reg[15:8] : rc_reg[31:24]))
		else $error("return code does not follow viewing decision");
	a_trailer_last: assert property (rsp_valid && rsp_last |-> out_pos == data_len + 8'h01)
		else $error("last byte is not the second status byte");
	a_byte_advance: assert property (rsp_valid && rsp_ready && !rsp_last |=> rsp_valid && out_pos == $past(out_pos) + 8'h01)
		else $error("gap or skip in response stream");
	a_stall_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_byte) && $stable(out_pos))
		else $error("response byte changed while stalled");
	a_wb_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	c_init_done: cover property (rsp_valid && rsp_ready && rsp_last && kind == ACR_KIND_INIT);
	c_ecm_view: cover property (rsp_valid && rsp_ready && rsp_last && kind == ACR_KIND_ECM && ctrl[0]);
	c_ecm_denied: cover property (rsp_valid && rsp_ready && rsp_last && kind == ACR_KIND_ECM && !ctrl[0]);
	c_unknown_cmd: cover property (rsp_valid && rsp_ready && rsp_last && kind == ACR_KIND_NONE);
endmodule

//--- hdl/acr_cmd_if.sv
`timescale 1ns/1ns
interface acr_cmd_if;
	logic       done;
	logic       hdr_ok;
	logic [7:0] ins;
	logic [7:0] lc;

	modport parser (output done, output hdr_ok, output ins, output lc);
	modport core   (input done, input hdr_ok, input ins, input lc);
endinterface

//--- hdl/acr_cmd_parse.sv
`timescale 1ns/1ns
module acr_cmd_parse
	import acr_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        take,
	input  wire logic [7:0]  cmd_byte,
	acr_cmd_if.parser        cmd
);
	typedef enum logic [2:0] {
		PS_CLA  = 3'b000,
		PS_INS  = 3'b001,
		PS_P1   = 3'b010,
		PS_P2   = 3'b011,
		PS_LEN  = 3'b100,
		PS_DATA = 3'b101,
		PS_LE   = 3'b110
	} acr_pstate_e;

	acr_pstate_e state;
	logic [7:0]  left;

	// a zero byte after the header is the expected length: the length byte is absent
	assign cmd.done = take && ((state == PS_LE) || ((state == PS_LEN) && (cmd_byte == ACR_P_ZERO)));

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state      <= PS_CLA;
			left       <= 8'h00;
			cmd.hdr_ok <= 1'b0;
			cmd.ins    <= 8'h00;
			cmd.lc     <= 8'h00;
		end else if (take) begin
			case (state)
				PS_CLA: begin
					cmd.hdr_ok <= (cmd_byte == ACR_CLA);
					// a command without data ends before its length is latched: do not keep the last one
					cmd.lc     <= 8'h00;
					state      <= PS_INS;
				end
				PS_INS: begin
					cmd.ins <= cmd_byte;
					state   <= PS_P1;
				end
				PS_P1: begin
					cmd.hdr_ok <= cmd.hdr_ok && (cmd_byte == ACR_P_ZERO);
					state      <= PS_P2;
				end
				PS_P2: begin
					cmd.hdr_ok <= cmd.hdr_ok && (cmd_byte == ACR_P_ZERO);
					state      <= PS_LEN;
				end
				PS_LEN: begin
					cmd.lc <= cmd_byte;
					left   <= cmd_byte;
					state  <= (cmd_byte == ACR_P_ZERO) ? PS_CLA : PS_DATA;
				end
				PS_DATA: begin
					left  <= left - 8'h01;
					state <= (left == 8'h01) ? PS_LE : PS_DATA;
				end
				PS_LE: begin
					state <= PS_CLA;
				end
				default: begin
					state <= PS_CLA;
				end
			endcase
		end
	end
endmodule

//--- hdl/acr_pkg.sv
package acr_pkg;
	// command header constants
	localparam logic [7:0]  ACR_CLA        = 8'h90;
	localparam logic [7:0]  ACR_INS_INIT   = 8'h30;
	localparam logic [7:0]  ACR_P_ZERO     = 8'h00;
	localparam logic [7:0]  ACR_UNIT_ZERO  = 8'h00;
	// response field encodings
	localparam logic [7:0]  ACR_TYPE_PREPAID  = 8'h00;
	localparam logic [7:0]  ACR_TYPE_STANDARD = 8'h01;
	localparam logic [7:0]  ACR_REC_NONE      = 8'h00;
	localparam logic [7:0]  ACR_REC_ALLOWED   = 8'h01;
	localparam logic [7:0]  ACR_REC_BUYER     = 8'h10;
	// payload layout, counted in bytes
	localparam logic [7:0]  ACR_UNIT_HDR   = 8'h04;
	localparam logic [7:0]  ACR_INIT_FIX   = 8'h33;
	localparam logic [7:0]  ACR_ECM_FIX    = 8'h11;
	localparam logic [7:0]  ACR_PRE_LEN    = 8'h02;
	localparam logic [7:0]  ACR_TYPE_FIELD = 8'h08;
	localparam logic [7:0]  ACR_CNT_FIELD  = 8'h32;
	localparam logic [7:0]  ACR_KEYS_LEN   = 8'h10;
	localparam logic [7:0]  ACR_SMID_MAX   = 8'h08;
	// profile memory byte offsets
	localparam logic [6:0]  ACR_MEM_ODD    = 7'h42;
	// register word offsets (byte address [8:2])
	localparam int          ACR_AW         = 9;
	localparam logic [6:0]  ACR_REG_CTRL   = 7'h00;
	localparam logic [6:0]  ACR_REG_INS    = 7'h01;
	localparam logic [6:0]  ACR_REG_INSTR  = 7'h02;
	localparam logic [6:0]  ACR_REG_RC     = 7'h03;
	localparam logic [6:0]  ACR_REG_SW     = 7'h04;
	localparam logic [6:0]  ACR_REG_STAT   = 7'h05;
	localparam logic [6:0]  ACR_MEM_BASE   = 7'h40;
	// control bit positions
	localparam int          ACR_CTRL_VIEW  = 0;
	localparam int          ACR_CTRL_GROUP = 1;
	localparam int          ACR_CTRL_STD   = 2;
	localparam int          ACR_CTRL_REC   = 4;
	// reset values
	localparam logic [5:0]  ACR_CTRL_RST   = 6'h04;
	localparam logic [31:0] ACR_INSTR_RST  = 32'h0001_0000;
	localparam logic [31:0] ACR_RC_RST     = 32'h0000_0000;
	localparam logic [31:0] ACR_SW_RST     = 32'h6D00_9000;

	typedef enum logic [1:0] {
		ACR_KIND_NONE = 2'b00,
		ACR_KIND_INIT = 2'b01,
		ACR_KIND_ECM  = 2'b10
	} acr_kind_e;
endpackage

//--- hdl/acr_prof_mem.sv
`timescale 1ns/1ns
module acr_prof_mem #(
	parameter int WORDS = 32
) (
	input  wire logic                       clock,
	input  wire logic                       rst_b,
	input  wire logic                       wr_en,
	input  wire logic [$clog2(WORDS)-1:0]   word_idx,
	input  wire logic [3:0]                 wr_sel,
	input  wire logic [31:0]                wr_data,
	output logic      [31:0]                rd_word,
	input  wire logic [$clog2(WORDS)+1:0]   byte_idx,
	output logic      [7:0]                 byte_out
);
	logic [7:0] mem [WORDS*4];

	assign rd_word  = {mem[{word_idx, 2'b11}], mem[{word_idx, 2'b10}],
	                   mem[{word_idx, 2'b01}], mem[{word_idx, 2'b00}]};
	assign byte_out = mem[byte_idx];

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < WORDS*4; i++) begin
				mem[i] <= 8'h00;
			end
		end else if (wr_en) begin
			for (int b = 0; b < 4; b++) begin
				if (wr_sel[b]) begin
					mem[{word_idx, 2'(b)}] <= wr_data[8*b +: 8];
				end
			end
		end
	end
endmodule

//--- verification/access_card_apdu_response_format_tb.sv
`timescale 1ns/1ns
module access_card_apdu_response_format_tb;
	import acr_pkg::*;
	localparam logic [31:0] instr_val = 32'hBEEF_1234;
	localparam logic [31:0] rc_val    = 32'hDEAD_0042;
	localparam logic [31:0] sw_val    = 32'h6A81_9001;
	logic        clock, rst_b, wb_cyc, wb_stb, wb_we, wb_ack_o, cmd_valid, cmd_ready;
	logic        rsp_valid, rsp_last, rsp_ready;
	logic [8:0]  wb_adr;
	logic [3:0]  wb_sel;
	logic [31:0] wb_dat, wb_dat_o, r;
	logic [7:0]  cmd_byte, rsp_byte, nval;
	logic [7:0]  exp_q[$], c[$];
	int          n_errors, tests_run, cycles;

	acr_card dut_u (.clock(clock), .rst_b(rst_b), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_byte(rsp_byte), .rsp_last(rsp_last), .rsp_ready(rsp_ready));
	acr_host_model host_u (.clock(clock), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rsp_last(rsp_last),
		.rsp_ready(rsp_ready));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic conclude;
		if (n_errors == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// the whole run needs well under a thousand cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 8000) begin
			n_errors++;
			conclude;
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wb(input logic we, input logic [6:0] w, input logic [31:0] d, input logic [3:0] s,
			output logic [31:0] rd);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= we;
		wb_adr <= {w, 2'b00};
		wb_dat <= d;
		wb_sel <= s;
		do @(posedge clock); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clock);
	endtask

	function automatic logic [7:0] prof(input int i);
		return (i == 49) ? nval : 8'(i * 7 + 3);
	endfunction

	task automatic fill(input logic [7:0] n);
		logic [31:0] d;
		nval = n;
		for (int w = 0; w < 21; w++) begin
			d = {prof(4 * w + 3), prof(4 * w + 2), prof(4 * w + 1), prof(4 * w)};
			wb(1'b1, ACR_MEM_BASE + 7'(w), d, 4'hF, d);
		end
	endtask

	task automatic push16(input logic [15:0] v);
		exp_q.push_back(v[15:8]);
		exp_q.push_back(v[7:0]);
	endtask

	task automatic exp_init(input logic grp, input logic std);
		exp_q = {8'h00, 8'(55 + 2 * nval)};
		push16(grp ? instr_val[31:16] : instr_val[15:0]);
		push16(rc_val[15:0]);
		for (int i = 0; i < 8; i++) exp_q.push_back(prof(i));
		exp_q.push_back(std ? ACR_TYPE_STANDARD : ACR_TYPE_PREPAID);
		for (int i = 8; i < 50 + 2 * nval; i++) exp_q.push_back(prof(i));
		push16(sw_val[15:0]);
	endtask

	task automatic run_cmd;
		host_u.rsp_q.delete();
		host_u.last_at = 0;
		host_u.send(c);
		while (host_u.last_at == 0) @(posedge clock);
		check("rsp_len", host_u.rsp_q.size(), exp_q.size());
		check("last_pos", host_u.last_at, exp_q.size());
		for (int i = 0; i < exp_q.size(); i++) check("rsp_byte", host_u.rsp_q[i], exp_q[i]);
		repeat (2) @(posedge clock);
	endtask

	initial begin
		rst_b = 1'b0;
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = '0;
		n_errors = 0;
		tests_run = 0;
		cycles = 0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		wb(1'b0, ACR_REG_CTRL, 32'h0, 4'hF, r);
		check("ctrl_rst", r, 32'(ACR_CTRL_RST));
		wb(1'b0, ACR_REG_INSTR, 32'h0, 4'hF, r);
		check("instr_rst", r, ACR_INSTR_RST);
		wb(1'b0, ACR_REG_SW, 32'h0, 4'hF, r);
		check("sw_rst", r, ACR_SW_RST);
		wb(1'b1, 7'h06, 32'hFFFF_FFFF, 4'hF, r);
		wb(1'b0, 7'h06, 32'h0, 4'hF, r);
		check("unmapped", r, 32'h0);
		wb(1'b1, ACR_REG_INSTR, instr_val, 4'hF, r);
		wb(1'b1, ACR_REG_RC, rc_val, 4'hF, r);
		wb(1'b1, ACR_REG_SW, sw_val, 4'hF, r);
		fill(8'h02);
		wb(1'b0, ACR_MEM_BASE, 32'h0, 4'hF, r);
		check("mem_word", r, {prof(3), prof(2), prof(1), prof(0)});
		wb(1'b0, 7'h60, 32'h0, 4'hF, r);
		check("beyond_mem", r, 32'h0);
		// standard card, no group, two identifiers
		wb(1'b1, ACR_REG_CTRL, 32'h05, 4'hF, r);
		c = {ACR_CLA, ACR_INS_INIT, 8'h00, 8'h00, 8'h00};
		exp_init(1'b0, 1'b1);
		run_cmd;
		wb(1'b0, ACR_REG_STAT, 32'h0, 4'hF, r);
		check("stat_kind", {r[23:16], r[2:0]}, {8'h01, 3'b010});
		// prepaid card with group id, maximum count, stalling host
		wb(1'b1, ACR_REG_CTRL, 32'h02, 4'h1, r);
		fill(8'h08);
		host_u.slow = 1'b1;
		exp_init(1'b1, 1'b0);
		run_cmd;
		host_u.slow = 1'b0;
		// every recording code, viewing denied and allowed in turn
		for (int k = 0; k < 4; k++) begin
			wb(1'b1, ACR_REG_CTRL, {26'h0, 2'(k), 3'b010, k[0]}, 4'hF, r);
			if (k == 2) begin
				wb(1'b1, ACR_REG_INS, 32'h36, 4'h1, r);
			end
			c = {ACR_CLA, (k < 2) ? 8'h34 : 8'h36, 8'h00, 8'h00, 8'(k + 1)};
			for (int j = 0; j <= k; j++) c.push_back(8'hA0 + 8'(j));
			c.push_back(8'h00);
			exp_q = {8'h00, 8'h15};
			push16(instr_val[15:0]);
			push16(k[0] ? rc_val[15:0] : rc_val[31:16]);
			for (int i = 66; i < 82; i++) exp_q.push_back(k[0] ? prof(i) : 8'h00);
			exp_q.push_back(k == 1 ? ACR_REC_ALLOWED : k == 2 ? ACR_REC_BUYER : ACR_REC_NONE);
			push16(sw_val[15:0]);
			run_cmd;
		end
		// a command without data right after a message must not inherit its length
		c = {ACR_CLA, ACR_INS_INIT, 8'h00, 8'h00, 8'h00};
		exp_init(1'b0, 1'b1);
		run_cmd;
		wb(1'b0, ACR_REG_STAT, 32'h0, 4'hF, r);
		check("stat_lc", r[23:0], 24'h07_0002);
		// bad class, then nonzero parameter: trailer only
		for (int k = 0; k < 2; k++) begin
			c = {k ? ACR_CLA : 8'h91, ACR_INS_INIT, 8'(k), 8'h00, 8'h00};
			exp_q = {};
			push16(sw_val[31:16]);
			run_cmd;
		end
		conclude;
	end
endmodule

//--- verification/acr_host_model.sv
`timescale 1ns/1ns
module acr_host_model (
	input  wire logic       clock,
	input  wire logic       rst_b,
	output logic            cmd_valid,
	output logic [7:0]      cmd_byte,
	input  wire logic       cmd_ready,
	input  wire logic       rsp_valid,
	input  wire logic [7:0] rsp_byte,
	input  wire logic       rsp_last,
	output logic            rsp_ready
);
	logic [7:0] rsp_q[$];
	int         last_at;
	logic       slow;

	initial begin
		cmd_valid = 1'b0;
		cmd_byte  = 8'hFF;
		rsp_ready = 1'b0;
		slow      = 1'b0;
		last_at   = 0;
	end

	// a stalling host drops ready every other cycle
	always @(posedge clock) begin
		if (rsp_valid && rsp_ready) begin
			rsp_q.push_back(rsp_byte);
			if (rsp_last) begin
				last_at <= rsp_q.size();
			end
		end
		rsp_ready <= rst_b && (slow ? ~rsp_ready : 1'b1);
	end

	// command bytes go in order, the line is scrambled once released
	task automatic send(input logic [7:0] c[$]);
		foreach (c[i]) begin
			cmd_valid <= 1'b1;
			cmd_byte  <= c[i];
			do @(posedge clock); while (cmd_ready !== 1'b1);
		end
		cmd_valid <= 1'b0;
		cmd_byte  <= ~c[c.size()-1];
	endtask
endmodule
